// ==== cbt_pkg.sv ====
// cbt_pkg: register map, field layout, reset values and timing counts
// for the bit-timing and event-flag block; shared by every module except cbt_bus_model.
package cbt_pkg;
	localparam int unsigned CLK_MHZ   = 250;
	localparam int unsigned FILT_NS   = 50;
	localparam int unsigned FILT_CYC  = (FILT_NS * CLK_MHZ + 999) / 1000;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_BT1    = 8'h00;
	localparam logic [7:0] OFF_BT2    = 8'h04;
	localparam logic [7:0] OFF_BT3    = 8'h08;
	localparam logic [7:0] OFF_IO     = 8'h0c;
	localparam logic [7:0] OFF_FLAGS  = 8'h10;
	localparam logic [7:0] OFF_EN     = 8'h14;
	localparam logic [7:0] OFF_CTRL   = 8'h18;
	localparam logic [7:0] OFF_STAT   = 8'h1c;

	// ---------------------------------------------------------------
	// reset values and writable masks
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] RST_CTRL   = 8'h80;
	localparam logic [7:0] BT3_MASK   = 8'h47;
	localparam logic [7:0] IO_MASK    = 8'h30;
	localparam logic [7:0] CTRL_MASK  = 8'he0;
	localparam logic [2:0] OP_CFG     = 3'h4;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int unsigned SJW_LSB   = 6;
	localparam int unsigned PH2F_BIT  = 7;
	localparam int unsigned TRIP_BIT  = 6;
	localparam int unsigned PH1_LSB   = 3;
	localparam int unsigned WFIL_BIT  = 6;
	localparam int unsigned DRVH_BIT  = 5;
	localparam int unsigned CAPR_BIT  = 4;
	localparam int unsigned OPRQ_LSB  = 5;
	localparam int unsigned F_INV     = 7;
	localparam int unsigned F_WAKE    = 6;
	localparam int unsigned F_ERR     = 5;
	localparam int unsigned F_TX0     = 2;
	localparam int unsigned F_RX0     = 0;
	localparam int unsigned ERR_N     = 4;

	localparam logic [4:0] IPT_TQ     = 5'h02;

	typedef struct packed {
		logic [1:0] resync_jump_width;
		logic [5:0] quantum_prescaler;
		logic       ph2_free;
		logic       triple;
		logic [2:0] ph1;
		logic [2:0] prop;
		logic [2:0] ph2;
	} cbt_timing_s;

	typedef enum logic [1:0] {SEG_SYNC, SEG_TSEG1, SEG_PH2} cbt_seg_e;
endpackage

// ==== cbt_tq_gen.sv ====
// cbt_tq_gen: time quantum tick from the system clock.
// assumes brp is held steady while the bit timer runs.
`timescale 1ns/1ps
module cbt_tq_gen
	import cbt_pkg::*;
(
	input  wire logic       clk,     // system clock
	input  wire logic       resetn,  // async reset, active low
	input  wire logic [5:0] quantum_prescaler,     // quantum_prescaler field
	output logic            tq_tick  // one pulse per time quantum
);
	logic [6:0] cnt_q;
	logic [6:0] last;

	// two clocks per prescaler step, so the divider is 2*(brp+1)
	assign last = {quantum_prescaler, 1'b1};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q   <= 7'h00;
			tq_tick <= 1'b0;
		end else if (cnt_q >= last) begin
			cnt_q   <= 7'h00;
			tq_tick <= 1'b1;
		end else begin
			cnt_q   <= cnt_q + 7'h01;
			tq_tick <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	logic [6:0] since_q;
	logic [5:0] brp_seen_q;
	logic       steady_q;

	// a period is only judged once it began under the current prescaler
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			since_q    <= 7'h00;
			brp_seen_q <= 6'h00;
			steady_q   <= 1'b0;
		end else begin
			since_q    <= tq_tick ? 7'h00 : since_q + 7'h01;
			brp_seen_q <= quantum_prescaler;
			if (quantum_prescaler != brp_seen_q)
				steady_q <= 1'b0;
			else if (tq_tick)
				steady_q <= 1'b1;
		end
	end

	tq_period_a: assert property (
		@(posedge clk) disable iff (!resetn)
		tq_tick && steady_q && quantum_prescaler == brp_seen_q
		|-> since_q == 7'(2 * (int'(quantum_prescaler) + 1) - 1))
		else $error("quantum period wrong");
endmodule

// ==== cbt_line_filter.sv ====
// cbt_line_filter: passes a level only after it has held steady
// for FILT_CYC clocks; input is already synchronised.
`timescale 1ns/1ps
module cbt_line_filter
	import cbt_pkg::*;
(
	input  wire logic clk,     // system clock
	input  wire logic resetn,  // async reset, active low
	input  wire logic din,     // raw synchronised bus level
	output logic      dout     // filtered level
);
	localparam logic [4:0] FCYC = 5'(FILT_CYC);
	logic [4:0] cnt_q;

	// short glitches restart the count and never reach the output
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 5'h00;
			dout  <= 1'b1;
		end else if (din == dout) begin
			cnt_q <= 5'h00;
		end else if (cnt_q >= FCYC - 5'h01) begin
			cnt_q <= 5'h00;
			dout  <= din;
		end else begin
			cnt_q <= cnt_q + 5'h01;
		end
	end
endmodule

// ==== cbt_core.sv ====
// cbt_core: bit-timing configuration, pin routing and event flags
// of a bus controller, reached over APB.
// Operation
// - resync jump width is field plus one quanta.
// - one quantum is 2*(prescaler+1) clock periods.
// - timing registers one and two are writable only in config mode.
// - phase 2 from own field if free, else max(phase 1, INFO_PROCESSING_TIME).
// - triple-sample bit takes majority of three samples, else one.
// - phase segment 1 lasts field plus one quanta.
// - propagation segment lasts field plus one quanta.
// - free phase segment 2 lasts field plus one quanta.
// - phase 2 field ignored when free-select bit is clear.
// - wake detection uses the line filter when selected.
// - recessive transmit pin drives high or floats per drive bit.
// - capture unit fed by message-receive signal or capture pin.
// - unimplemented bits read zero and ignore writes.
// - invalid message sets the invalid-message flag.
// - bus activity sets the wake flag.
// - any error source sets the one shared error flag.
// - each transmit buffer done sets its flag at bits 4..2.
// - each receive buffer full sets its flag at bits 1..0.
// - invalid-message request only while its enable is set.
// - wake request only while its enable is set.
// assumes an APB master on clk and a bit engine on the same clock.
`timescale 1ns/1ps
module cbt_core
	import cbt_pkg::*;
(
	input  wire logic         clk,          // 250 MHz system clock
	input  wire logic         resetn,       // async reset, active low
	input  wire logic         psel,         // apb select
	input  wire logic         penable,      // apb access phase
	input  wire logic         pwrite,       // apb direction
	input  wire logic [7:0]   paddr,        // apb byte address
	input  wire logic [31:0]  pwdata,       // apb write data
	output logic [31:0]       prdata,       // apb read data
	output logic              pready,       // apb ready
	output logic              pslverr,      // apb error, unmapped
	input  wire logic         bus_rx_pin,   // bus receive pin
	input  wire logic         capture_input_pin, // capture pin
	input  wire logic         msg_rx_sig,   // engine receive signal
	input  wire logic         tx_bit,       // engine bit, 1 recessive
	input  wire logic         invalid_evt,  // invalid message pulse
	input  wire logic [ERR_N-1:0] err_evt,  // error source pulses
	input  wire logic [2:0]   tx_done_evt,  // tx buffer done pulses
	input  wire logic [1:0]   rx_full_evt,  // rx buffer full pulses
	output logic              bus_transmit_pin_o,  // pin level
	output logic              bus_transmit_pin_oe, // pin enable
	output logic              capture_out,  // capture unit input
	output logic              tq_pulse,     // time quantum tick
	output logic              sample_pulse, // sample point strobe
	output logic              sampled_bit,  // bit taken at sample
	output logic [2:0]        sjw_tq,       // jump width in quanta
	output logic [4:0]        bit_len_tq,   // nominal bit quanta
	output logic [7:0]        irq_req       // flag and enable
);
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0]  bt1_q, bt2_q, bt3_q, io_q, flags_q, en_q, ctrl_q;
	logic [7:0]  flags_d, ev_vec;
	cbt_timing_s tim;
	logic        wr_acc, in_cfg;
	logic        rx_lvl_q, cap_lvl_q, rx_prev_q, wake_src_prev_q;
	logic        filt_rx, wake_src, rx_fall, tq_tick;

	assign tim = '{resync_jump_width: bt1_q[7:6], quantum_prescaler: bt1_q[5:0],
		ph2_free: bt2_q[PH2F_BIT], triple: bt2_q[TRIP_BIT],
		ph1: bt2_q[5:3], prop: bt2_q[2:0], ph2: bt3_q[2:0]};
	assign in_cfg = (ctrl_q[7:5] == OP_CFG);
	assign wr_acc = psel && penable && pready && pwrite;

	function automatic logic hit(input logic [7:0] a);
		return a == OFF_BT1 || a == OFF_BT2 || a == OFF_BT3 ||
			a == OFF_IO || a == OFF_FLAGS || a == OFF_EN ||
			a == OFF_CTRL || a == OFF_STAT;
	endfunction

	// ---------------------------------------------------------------
	// apb slave: answers in the first access cycle
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (psel && !penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= !hit(paddr);
			unique case (paddr)
				OFF_BT1:   prdata <= {24'h000000, bt1_q};
				OFF_BT2:   prdata <= {24'h000000, bt2_q};
				OFF_BT3:   prdata <= {24'h000000, bt3_q};
				OFF_IO:    prdata <= {24'h000000, io_q};
				OFF_FLAGS: prdata <= {24'h000000, flags_q};
				OFF_EN:    prdata <= {24'h000000, en_q};
				OFF_CTRL:  prdata <= {24'h000000, ctrl_q};
				OFF_STAT:  prdata <= {24'h000000, sampled_bit,
					2'b00, bit_len_tq};
				default:   prdata <= 32'h00000000;
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// timing registers one and two hold while not in config mode
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bt1_q <= RST_ZERO;
			bt2_q <= RST_ZERO;
		end else if (wr_acc && in_cfg) begin
			if (paddr == OFF_BT1)
				bt1_q <= pwdata[7:0];
			if (paddr == OFF_BT2)
				bt2_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bt3_q  <= RST_ZERO;
			io_q   <= RST_ZERO;
			en_q   <= RST_ZERO;
			ctrl_q <= RST_CTRL;
		end else if (wr_acc) begin
			if (paddr == OFF_BT3)
				bt3_q <= pwdata[7:0] & BT3_MASK;
			if (paddr == OFF_IO)
				io_q <= pwdata[7:0] & IO_MASK;
			if (paddr == OFF_EN)
				en_q <= pwdata[7:0];
			if (paddr == OFF_CTRL)
				ctrl_q <= pwdata[7:0] & CTRL_MASK;
		end
	end

	// ---------------------------------------------------------------
	// event flags: a hardware set wins over a software clear
	// ---------------------------------------------------------------
	assign ev_vec = {invalid_evt,
		wake_src_prev_q && !wake_src,
		|err_evt,
		tx_done_evt,
		rx_full_evt};

	always_comb begin
		flags_d = flags_q;
		if (wr_acc && paddr == OFF_FLAGS)
			flags_d = pwdata[7:0];
		flags_d = flags_d | ev_vec;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_q <= RST_ZERO;
			irq_req <= RST_ZERO;
		end else begin
			flags_q <= flags_d;
			irq_req <= flags_q & en_q;
		end
	end

	// ---------------------------------------------------------------
	// pin inputs: three flops, a change counts when two and three agree
	// ---------------------------------------------------------------
	logic [1:0] pin_in;
	logic [2:0] sync_q [2];
	assign pin_in = {capture_input_pin, bus_rx_pin};

	for (genvar g = 0; g < 2; g++) begin : g_sync
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn)
				sync_q[g] <= 3'h7;
			else
				sync_q[g] <= {sync_q[g][1:0], pin_in[g]};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_lvl_q  <= 1'b1;
			cap_lvl_q <= 1'b1;
		end else begin
			if (sync_q[0][1] == sync_q[0][2])
				rx_lvl_q <= sync_q[0][2];
			if (sync_q[1][1] == sync_q[1][2])
				cap_lvl_q <= sync_q[1][2];
		end
	end

	cbt_line_filter u_filt (
		.clk    (clk),
		.resetn (resetn),
		.din    (rx_lvl_q),
		.dout   (filt_rx)
	);

	// the filter costs FILT_CYC clocks of wake latency
	assign wake_src = bt3_q[WFIL_BIT] ? filt_rx : rx_lvl_q;

	// ---------------------------------------------------------------
	// pin outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_transmit_pin_o  <= 1'b1;
			bus_transmit_pin_oe <= 1'b0;
			capture_out         <= 1'b1;
			wake_src_prev_q     <= 1'b1;
			rx_prev_q           <= 1'b1;
		end else begin
			bus_transmit_pin_o  <= tx_bit;
			bus_transmit_pin_oe <= !tx_bit || io_q[DRVH_BIT];
			capture_out <= io_q[CAPR_BIT] ? msg_rx_sig
				: cap_lvl_q;
			wake_src_prev_q     <= wake_src;
			rx_prev_q           <= rx_lvl_q;
		end
	end

	// ---------------------------------------------------------------
	// bit timer
	// ---------------------------------------------------------------
	cbt_tq_gen u_tq (
		.clk     (clk),
		.resetn  (resetn),
		.quantum_prescaler     (tim.quantum_prescaler),
		.tq_tick (tq_tick)
	);

	logic [4:0] tseg1_len, ph1_len, ph2_len, sjw_len, ph2_rem;
	logic [4:0] qcnt_q, ext_q;
	logic [2:0] hist_q;
	logic       resynced_q;
	cbt_seg_e   seg_q;

	assign ph1_len   = {2'b00, tim.ph1} + 5'h01;
	assign tseg1_len = {2'b00, tim.prop} + 5'h01 + ph1_len;
	assign sjw_len   = {3'b000, tim.resync_jump_width} + 5'h01;
	assign ph2_len = tim.ph2_free ? {2'b00, tim.ph2} + 5'h01
		: (ph1_len > IPT_TQ ? ph1_len : IPT_TQ);
	assign ph2_rem = ph2_len - qcnt_q;
	assign rx_fall = rx_prev_q && !rx_lvl_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sjw_tq     <= 3'h1;
			bit_len_tq <= 5'h05;
			tq_pulse   <= 1'b0;
		end else begin
			sjw_tq     <= sjw_len[2:0];
			bit_len_tq <= 5'h01 + tseg1_len + ph2_len;
			tq_pulse   <= tq_tick;
		end
	end

	// a late edge stretches phase 1 by up to the jump width; an early
	// edge in phase 2 ends the bit only when within the jump width
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seg_q        <= SEG_SYNC;
			qcnt_q       <= 5'h00;
			ext_q        <= 5'h00;
			resynced_q   <= 1'b0;
			hist_q       <= 3'h7;
			sample_pulse <= 1'b0;
			sampled_bit  <= 1'b1;
		end else begin
			sample_pulse <= 1'b0;
			if (rx_fall && !resynced_q && seg_q == SEG_TSEG1) begin
				resynced_q <= 1'b1;
				ext_q <= (qcnt_q + 5'h01 < sjw_len)
					? qcnt_q + 5'h01 : sjw_len;
			end else if (rx_fall && !resynced_q &&
				seg_q == SEG_PH2 && ph2_rem <= sjw_len) begin
				resynced_q <= 1'b1;
				seg_q      <= SEG_SYNC;
				qcnt_q     <= 5'h00;
			end else if (tq_tick) begin
				hist_q <= {hist_q[1:0], rx_lvl_q};
				unique case (seg_q)
					SEG_SYNC: begin
						seg_q      <= SEG_TSEG1;
						qcnt_q     <= 5'h00;
						ext_q      <= 5'h00;
						resynced_q <= 1'b0;
					end
					SEG_TSEG1: begin
						if (qcnt_q >= tseg1_len + ext_q - 5'h01) begin
							seg_q        <= SEG_PH2;
							qcnt_q       <= 5'h00;
							sample_pulse <= 1'b1;
							sampled_bit  <= tim.triple
								? maj({hist_q[1:0], rx_lvl_q})
								: rx_lvl_q;
						end else begin
							qcnt_q <= qcnt_q + 5'h01;
						end
					end
					SEG_PH2: begin
						if (qcnt_q >= ph2_len - 5'h01) begin
							seg_q  <= SEG_SYNC;
							qcnt_q <= 5'h00;
						end else begin
							qcnt_q <= qcnt_q + 5'h01;
						end
					end
				endcase
			end
		end
	end

	function automatic logic maj(input logic [2:0] v);
		return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	cfg_lock_a: assert property (
		wr_acc && !in_cfg && paddr == OFF_BT1 |=> $stable(bt1_q))
		else $error("timing write outside config");
	ph2_len_a: assert property (
		ph2_len == (bt2_q[PH2F_BIT] ? 5'(bt3_q[2:0]) + 5'h01
		: (5'(bt2_q[5:3]) + 5'h01 > IPT_TQ
		? 5'(bt2_q[5:3]) + 5'h01 : IPT_TQ)))
		else $error("phase 2 length wrong");
	jump_width_a: assert property (
		##1 $stable(bt1_q) |-> sjw_tq == 3'(bt1_q[7:6]) + 3'h1)
		else $error("jump width wrong");
	bit_len_a: assert property (
		$stable(bt2_q) && $stable(bt3_q) |->
		bit_len_tq == 5'(tim.prop) + 5'(tim.ph1) + ph2_len + 5'h03)
		else $error("nominal bit length wrong");
	tx_float_a: assert property (
		tx_bit && !io_q[DRVH_BIT] |=> !bus_transmit_pin_oe)
		else $error("recessive pin driven");
	tx_dom_a: assert property (
		!tx_bit |=> bus_transmit_pin_oe && !bus_transmit_pin_o)
		else $error("dominant not driven");
	cap_route_a: assert property (
		io_q[CAPR_BIT] |=> capture_out == $past(msg_rx_sig))
		else $error("capture route wrong");
	flag_set_a: assert property (
		|ev_vec |=> (flags_q & $past(ev_vec)) == $past(ev_vec))
		else $error("event flag lost");
	flag_hold_a: assert property (
		flags_q[F_INV] && !wr_acc |=> flags_q[F_INV])
		else $error("flag dropped");
	inv_irq_a: assert property (
		irq_req[F_INV] |-> $past(flags_q[F_INV] && en_q[F_INV]))
		else $error("invalid request ungated");
	wake_irq_a: assert property (
		flags_q[F_WAKE] && !en_q[F_WAKE] |=> !irq_req[F_WAKE])
		else $error("wake request ungated");
	unimpl_a: assert property (
		(bt3_q & ~BT3_MASK) == 8'h00 && (io_q & ~IO_MASK) == 8'h00)
		else $error("unimplemented bit set");
	single_sample_a: assert property (
		sample_pulse && !tim.triple && $stable(bt2_q)
		|-> sampled_bit == $past(rx_lvl_q))
		else $error("single sample wrong");

	cfg_write_c: cover property (wr_acc && in_cfg && paddr == OFF_BT2);
	triple_c: cover property (sample_pulse && tim.triple);
	resync_c: cover property (rx_fall && seg_q == SEG_PH2);
endmodule

// ==== cbt_bus_model.sv ====
// cbt_bus_model: behavioural bus transceiver with one other node.
// assumes the design's transmit pin pair and a bench-driven node.
`timescale 1ns/1ps
module cbt_bus_model (
	input  wire logic pin_o,     // transmit pin level
	input  wire logic pin_oe,    // transmit pin enable
	input  wire logic other_dom, // other node drives dominant
	output logic      bus_rx     // receive level, 0 dominant
);
	// termination holds recessive, so a floating pin reads 1
	assign bus_rx = ~((pin_oe & ~pin_o) | other_dom);
endmodule

// ==== testbench.sv ====
// testbench: random and corner tests of the timing and flag block.
// assumes cbt_pkg offsets and a zero-wait-state apb slave.
`timescale 1ns/1ps
module testbench;
	import cbt_pkg::*;
	logic        clk, resetn, psel, penable, pwrite;
	logic [7:0]  paddr, irq, v, u, b1, b2;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, e, rx, cpin, mrx, txb, dom;
	logic        pin_o, pin_oe, cout, qpulse, smp, sbit;
	logic [9:0]  ev;
	logic [2:0]  jw;
	logic [4:0]  blen;
	int          miscompares, compares, g, n, fb;

	cbt_core DUT (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_rx_pin(rx), .capture_input_pin(cpin),
		.msg_rx_sig(mrx), .tx_bit(txb), .invalid_evt(ev[9]),
		.err_evt(ev[8:5]), .tx_done_evt(ev[4:2]), .rx_full_evt(ev[1:0]),
		.bus_transmit_pin_o(pin_o), .bus_transmit_pin_oe(pin_oe),
		.capture_out(cout), .tq_pulse(qpulse), .sample_pulse(smp),
		.sampled_bit(sbit), .sjw_tq(jw), .bit_len_tq(blen),
		.irq_req(irq));
	cbt_bus_model bus (.pin_o(pin_o), .pin_oe(pin_oe),
		.other_dom(dom), .bus_rx(rx));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] gv, input logic [31:0] xv,
		input string m);
		compares++;
		if (gv !== xv) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, gv,
				xv);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		// no local limit: only the watchdog ends a missing answer
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] x,
		input logic xe);
		apb(1'b0, a, 8'h00);
		chk(r, {24'h0, x}, $sformatf("read %h", a));
		chk(32'(e), 32'(xe), $sformatf("slverr %h", a));
	endtask

	// counts clocks between two quantum pulses
	task automatic qgap(output int gg);
		gg = 0;
		while (qpulse !== 1'b1 && gg < 300) begin
			@(posedge clk);
			gg++;
		end
		gg = 0;
		do begin
			@(posedge clk);
			gg++;
		end while (qpulse !== 1'b1 && gg < 300);
	endtask

	function automatic logic [4:0] exp_len(logic [7:0] c2, logic [7:0] c3);
		logic [4:0] p1, p2;
		p1 = {2'b0, c2[5:3]} + 5'd1;
		p2 = c2[7] ? {2'b0, c3[2:0]} + 5'd1 : (p1 > IPT_TQ ? p1 : IPT_TQ);
		return 5'd2 + {2'b0, c2[2:0]} + p1 + p2;
	endfunction

	task automatic tally_and_finish;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#200000;
		miscompares++;
		tally_and_finish;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cpin = 1'b0;
		mrx = 1'b0;
		txb = 1'b1;
		dom = 1'b0;
		ev = 10'h0;
		b1 = 8'h00;
		b2 = 8'h00;
		miscompares = 0;
		compares = 0;
		void'($urandom(32'ha89112db));
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		for (int a = 0; a <= 20; a += 4) begin
			rd(8'(a), RST_ZERO, 1'b0);
		end
		rd(OFF_CTRL, RST_CTRL, 1'b0);
		rd(8'h20, 8'h00, 1'b1);
		// every mode request code; only config lets timing through
		for (int k = 0; k < 8; k++) begin
			v = 8'($urandom);
			wr(OFF_CTRL, 8'(k << 5));
			rd(OFF_CTRL, 8'(k << 5), 1'b0);
			wr(OFF_BT1, v);
			wr(OFF_BT2, v ^ 8'h5a);
			if (k == 4) begin
				b1 = v;
				b2 = v ^ 8'h5a;
			end
			rd(OFF_BT1, b1, 1'b0);
			rd(OFF_BT2, b2, 1'b0);
		end
		wr(OFF_CTRL, RST_CTRL);
		wr(OFF_BT3, 8'hff);
		rd(OFF_BT3, BT3_MASK, 1'b0);
		wr(OFF_IO, 8'hff);
		rd(OFF_IO, IO_MASK, 1'b0);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			wr(OFF_BT1, v);
			qgap(g);
			qgap(g);
			chk(32'(g), 32'(2 * (v[5:0] + 1)), "quantum");
			chk(32'(jw), 32'(v[7:6]) + 1, "jump width");
		end
		// shortest quantum keeps a whole bit inside the strobe wait
		wr(OFF_BT1, 8'h00);
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
			u = 8'($urandom);
			wr(OFF_BT2, v);
			wr(OFF_BT3, u);
			repeat (3) @(posedge clk);
			chk(32'(blen), 32'(exp_len(v, u)), "bit length");
			rd(OFF_STAT, {1'h1, 2'h0, exp_len(v, u)}, 1'b0);
			n = 0;
			while (smp !== 1'b1 && n < 100) begin
				@(posedge clk);
				n++;
			end
			chk(32'(smp), 32'h1, "sample strobe");
			chk(32'(sbit), 32'h1, "idle sampled level");
		end
		for (int i = 0; i < 16; i++) begin
			v = 8'($urandom);
			wr(OFF_IO, v & IO_MASK);
			txb <= v[0];
			mrx <= v[1];
			cpin <= v[2];
			repeat (6) @(posedge clk);
			chk(32'(pin_oe), 32'(!v[0] | v[5]), "pin enable");
			if (!v[0] | v[5])
				chk(32'(pin_o), 32'(v[0]), "pin level");
			chk(32'(cout), 32'(v[4] ? v[1] : v[2]), "capture");
		end
		txb <= 1'b1;
		repeat (30) @(posedge clk);
		// event sources; the last three repeat invalid with mask on/off
		for (int i = 0; i < 12; i++) begin
			n = (i < 10) ? i : 9;
			fb = (n < 5) ? n : (n < 9) ? 5 : 7;
			u = 8'($urandom);
			if (i >= 9)
				u[fb] = i[0];
			wr(OFF_FLAGS, 8'h00);
			wr(OFF_EN, u);
			@(posedge clk);
			ev <= 10'h1 << n;
			@(posedge clk);
			ev <= 10'h0;
			repeat (3) @(posedge clk);
			chk(32'(irq), 32'((8'h1 << fb) & u), "request");
			rd(OFF_FLAGS, 8'h1 << fb, 1'b0);
		end
		wr(OFF_FLAGS, 8'h00);
		rd(OFF_FLAGS, 8'h00, 1'b0);
		// short bursts pass unfiltered only; a long one always wakes
		for (int i = 0; i < 3; i++) begin
			wr(OFF_BT3, (i == 0) ? 8'h00 : 8'h40);
			wr(OFF_FLAGS, 8'h00);
			wr(OFF_EN, 8'h40);
			n = (i == 0) ? 4 : (i == 1) ? 6 : 40;
			@(posedge clk);
			dom <= 1'b1;
			repeat (n) @(posedge clk);
			dom <= 1'b0;
			repeat (25) @(posedge clk);
			rd(OFF_FLAGS, (i == 1) ? 8'h00 : 8'h40, 1'b0);
			chk(32'(irq), (i == 1) ? 32'h0 : 32'h40, "wake request");
		end
		wr(OFF_EN, 8'h00);
		repeat (3) @(posedge clk);
		chk(32'(irq), 32'h0, "wake masked");
		tally_and_finish;
	end
endmodule
